/* File: rtl/tape_unit_command_handler.sv */
// command handler for a streaming tape unit, registers over apb
// assumes the drive sequencer acks each motion with a one-cycle drive_done
// How it works
// RULE1: release by owner drops reservation
// RULE2: release by other host gives conflict
// RULE3: erase is one forward motion
// RULE4: erase off start marker: check, sense 5
// RULE5: erase with byte1 bit0 clear rejected
// RULE6: disconnect during erase, reconnect after
// RULE7: mode sense sends requested byte count
// RULE8: record is 17 bytes, shorter truncates
// RULE9: set-parameters values reported when last
// RULE10: retension: rewind, end, rewind first
// RULE11: host should retension new tapes
// RULE12: load goes to start, measures length
// RULE13: unload parks at end or start
// RULE14: no immediate: status after motion
// RULE15: immediate: good status at motion start
// RULE16: busy status during immediate motion
// RULE17: disconnect during load/unload motion
// RULE18: bus clear or reset drops reservation
// RULE19: other host access gives conflict
// RULE20: lun from byte1 upper three bits
module tape_unit_command_handler import tape_cmd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive sequencer
  output logic drive_req,
  output logic [2:0] drive_op,
  input wire logic drive_done,
  input wire logic tape_start_marker,
  // host bus link state
  output logic disconnected,
  output logic reconnect
);
  // core state
  state_t state_reg, state_next;
  logic [31:0] cdb_lo_reg, cdb_lo_next; // bytes 0..3
  logic [15:0] cdb_hi_reg, cdb_hi_next; // bytes 4..5
  logic [2:0] host_reg, host_next; // sending host id
  logic disc_ok_reg, disc_ok_next; // host may disconnect
  logic [7:0] status_reg, status_next;
  logic [3:0] sense_reg, sense_next;
  logic done_reg, done_next; // sticky status posted
  logic busy_reg, busy_next; // immediate motion running
  logic disc_reg, disc_next; // off the bus
  logic recon_reg, recon_next; // reconnect pulse
  logic resv_reg, resv_next; // reservation held
  logic [2:0] owner_reg, owner_next;
  logic [2:0] lun_reg, lun_next;
  logic [4:0] count_reg, count_next; // mode sense byte count
  logic [2:0] step_reg, step_next;
  logic erase_reg, erase_next;
  logic retension_flag_reg, retension_flag_next;
  logic load_reg, load_next;
  logic park_end_reg, park_end_next;
  logic immed_reg, immed_next;
  logic [7:0] rec_reg [REC_LEN]; // configuration record
  logic [7:0] rec_next [REC_LEN];
  logic [4:0] idx_reg, idx_next; // record window index
  logic [7:0] sp_tracks_reg, sp_tracks_next;
  logic sp_last_reg, sp_last_next; // set-parameters came last
  logic [31:0] prdata_reg, prdata_next;
  // decoded command fields
  logic [7:0] opcode;
  logic [7:0] byte1;
  logic [7:0] byte4;
  logic [7:0] byte5;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic go;
  logic other_owns;
  motion_t cur_op;
  motion_t next_op;
  logic [7:0] rec_view;

  assign opcode = cdb_lo_reg[7:0];
  assign byte1 = cdb_lo_reg[15:8];
  assign byte4 = cdb_hi_reg[7:0];
  assign byte5 = cdb_hi_reg[15:8];
  // apb strobes, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = (paddr == ADDR_CDB_LO) || (paddr == ADDR_CDB_HI) || (paddr == ADDR_CTRL)
               || (paddr == ADDR_STATUS) || (paddr == ADDR_MODE) || (paddr == ADDR_SETP);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign go = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_GO];
  // RULE19: foreign host check
  assign other_owns = resv_reg && (owner_reg != host_reg);
  // no request while the step holds nothing, e.g. retension with no final op
  assign drive_req = (state_reg == S_MOTION) && (cur_op != M_NONE);
  assign drive_op = cur_op;
  assign disconnected = disc_reg;
  assign reconnect = recon_reg;

  // motion for a given step of the held command
  function automatic motion_t op_at(input logic [2:0] s);
    motion_t fin;
    // RULE12: load then measure
    // RULE13: unload park place
    fin = load_reg ? M_LOAD : (retension_flag_reg ? M_NONE : (park_end_reg ? M_TO_END : M_REWIND));
    // RULE3: single forward erase
    if (erase_reg) begin
      op_at = (s == STEP_FIRST) ? M_ERASE : M_NONE;
    // RULE10: retension prefix
    end else if (retension_flag_reg && (s < RETENSION_FLAG_STEPS)) begin
      op_at = (s == STEP_TO_END) ? M_TO_END : M_REWIND;
    end else if (s == (retension_flag_reg ? RETENSION_FLAG_STEPS : STEP_FIRST)) begin
      op_at = fin;
    end else begin
      op_at = M_NONE;
    end
  endfunction

  // op_at reads the held command flags, so keep it inside a process
  always_comb begin
    cur_op = op_at(step_reg);
    next_op = op_at(step_reg + 3'h1);
  end

  // record byte as mode sense reports it
  always_comb begin
    // RULE9: set-parameters override
    if (sp_last_reg && (idx_reg == TRACKS_IDX)) begin
      rec_view = sp_tracks_reg;
    end else if (idx_reg < REC_LEN) begin
      rec_view = rec_reg[idx_reg];
    end else begin
      rec_view = 8'h00;
    end
  end

  // read data captured in the setup cycle
  always_comb begin
    prdata_next = prdata_reg;
    if (rd_setup) begin
      if (paddr == ADDR_CDB_LO) begin
        prdata_next = cdb_lo_reg;
      end else if (paddr == ADDR_CDB_HI) begin
        prdata_next = {11'h000, disc_ok_reg, 1'b0, host_reg, cdb_hi_reg};
      end else if (paddr == ADDR_STATUS) begin
        prdata_next = {3'h0, count_reg, 1'b0, lun_reg, 1'b0, owner_reg, resv_reg,
                       disc_reg, busy_reg, done_reg, sense_reg, status_reg};
      end else if (paddr == ADDR_MODE) begin
        prdata_next = {16'h0000, rec_view, 3'h0, idx_reg};
      end else if (paddr == ADDR_SETP) begin
        prdata_next = {23'h000000, sp_last_reg, sp_tracks_reg};
      end else begin
        prdata_next = 32'h00000000; // ctrl and unmapped read zero
      end
    end
  end

  // next state of the command engine
  always_comb begin
    state_next = state_reg;
    cdb_lo_next = cdb_lo_reg;
    cdb_hi_next = cdb_hi_reg;
    host_next = host_reg;
    disc_ok_next = disc_ok_reg;
    status_next = status_reg;
    sense_next = sense_reg;
    done_next = done_reg;
    busy_next = busy_reg;
    disc_next = disc_reg;
    recon_next = 1'b0;
    resv_next = resv_reg;
    owner_next = owner_reg;
    lun_next = lun_reg;
    count_next = count_reg;
    step_next = step_reg;
    erase_next = erase_reg;
    retension_flag_next = retension_flag_reg;
    load_next = load_reg;
    park_end_next = park_end_reg;
    immed_next = immed_reg;
    rec_next = rec_reg;
    idx_next = idx_reg;
    sp_tracks_next = sp_tracks_reg;
    sp_last_next = sp_last_reg;
    // command loading only while idle
    if (wr_en && (paddr == ADDR_CDB_LO) && (state_reg == S_IDLE)) begin
      cdb_lo_next = pwdata;
    end
    if (wr_en && (paddr == ADDR_CDB_HI) && (state_reg == S_IDLE)) begin
      cdb_hi_next = pwdata[15:0];
      host_next = pwdata[HI_ID_LSB +: 3];
      disc_ok_next = pwdata[HI_DISC];
    end
    // mode select path into the record
    if (wr_en && (paddr == ADDR_MODE)) begin
      idx_next = pwdata[4:0];
      if (pwdata[MODE_WE] && (pwdata[4:0] < REC_LEN)) begin
        rec_next[pwdata[4:0]] = pwdata[15:8];
      end
      sp_last_next = 1'b0;
    end
    if (wr_en && (paddr == ADDR_SETP)) begin
      sp_tracks_next = pwdata[7:0];
      sp_last_next = 1'b1;
    end
    // acknowledge first so a new status wins
    if (wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_ACK]) begin
      done_next = 1'b0;
    end
    // RULE18: bus reset, abort, device reset
    if (wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_BUS_CLEAR]) begin
      resv_next = 1'b0;
    end
    case (state_reg)
      S_IDLE: begin
        if (go) begin
          state_next = S_EXEC;
        end
      end
      S_EXEC: begin
        // RULE20: lun capture
        lun_next = byte1[7:5];
        state_next = S_IDLE;
        done_next = 1'b1;
        status_next = ST_GOOD;
        sense_next = SK_NONE;
        erase_next = 1'b0;
        retension_flag_next = 1'b0;
        load_next = 1'b0;
        park_end_next = 1'b0;
        immed_next = 1'b0;
        step_next = STEP_FIRST;
        // RULE2: conflict on foreign release
        // RULE19: conflict for all commands
        if (other_owns) begin
          status_next = ST_CONFLICT;
        end else if (opcode == OP_RESERVE) begin
          resv_next = 1'b1;
          owner_next = host_reg;
        // RULE1: owner releases
        end else if (opcode == OP_RELEASE) begin
          resv_next = 1'b0;
        end else if (opcode == OP_ERASE) begin
          // RULE5: erase bit required
          // RULE4: must start at marker
          if (!byte1[0] || !tape_start_marker) begin
            status_next = ST_CHECK;
            sense_next = SK_ILLEGAL;
          end else begin
            erase_next = 1'b1;
            done_next = done_reg;
            state_next = S_MOTION;
            // RULE6: leave bus for erase
            disc_next = disc_ok_reg;
          end
        end else if (opcode == OP_SENSE) begin
          // RULE7: requested count
          // RULE8: capped at record length
          count_next = (byte4 > {3'h0, REC_LEN}) ? REC_LEN : byte4[4:0];
          idx_next = 5'h00;
        end else if (opcode == OP_LOADU) begin
          retension_flag_next = byte4[1];
          load_next = byte4[0];
          park_end_next = byte5[7];
          immed_next = byte1[0];
          state_next = S_MOTION;
          // RULE17: leave bus for motion
          disc_next = disc_ok_reg && !byte1[0];
          // RULE15: early good status
          // RULE14: otherwise hold status back
          done_next = byte1[0] ? 1'b1 : done_reg;
          busy_next = byte1[0];
        end else begin
          status_next = ST_CHECK;
          sense_next = SK_ILLEGAL;
        end
      end
      S_MOTION: begin
        if (cur_op == M_NONE) begin
          state_next = S_FINISH; // retension only, nothing to do
        end else if (drive_done) begin
          step_next = step_reg + 3'h1;
          if (next_op == M_NONE) begin
            state_next = S_FINISH;
          end
        end
      end
      S_FINISH: begin
        state_next = S_IDLE;
        busy_next = 1'b0;
        disc_next = 1'b0;
        recon_next = disc_reg;
        if (!immed_reg) begin
          done_next = 1'b1;
          status_next = ST_GOOD;
          sense_next = SK_NONE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // RULE16: busy answer while engaged
    if (go && (state_reg != S_IDLE)) begin
      done_next = 1'b1;
      status_next = ST_BUSYC;
      sense_next = SK_NONE;
    end
  end

  // register everything
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      cdb_lo_reg <= 32'h00000000;
      cdb_hi_reg <= 16'h0000;
      host_reg <= 3'h0;
      disc_ok_reg <= 1'b0;
      status_reg <= ST_GOOD;
      sense_reg <= SK_NONE;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      disc_reg <= 1'b0;
      recon_reg <= 1'b0;
      resv_reg <= 1'b0;
      owner_reg <= 3'h0;
      lun_reg <= 3'h0;
      count_reg <= 5'h00;
      step_reg <= STEP_FIRST;
      erase_reg <= 1'b0;
      retension_flag_reg <= 1'b0;
      load_reg <= 1'b0;
      park_end_reg <= 1'b0;
      immed_reg <= 1'b0;
      for (int i = 0; i < REC_LEN; i++) begin
        rec_reg[i] <= 8'h00;
      end
      idx_reg <= 5'h00;
      sp_tracks_reg <= 8'h00;
      sp_last_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      cdb_lo_reg <= cdb_lo_next;
      cdb_hi_reg <= cdb_hi_next;
      host_reg <= host_next;
      disc_ok_reg <= disc_ok_next;
      status_reg <= status_next;
      sense_reg <= sense_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      disc_reg <= disc_next;
      recon_reg <= recon_next;
      resv_reg <= resv_next;
      owner_reg <= owner_next;
      lun_reg <= lun_next;
      count_reg <= count_next;
      step_reg <= step_next;
      erase_reg <= erase_next;
      retension_flag_reg <= retension_flag_next;
      load_reg <= load_next;
      park_end_reg <= park_end_next;
      immed_reg <= immed_next;
      rec_reg <= rec_next;
      idx_reg <= idx_next;
      sp_tracks_reg <= sp_tracks_next;
      sp_last_reg <= sp_last_next;
      prdata_reg <= prdata_next;
    end
  end

  // checks on the command engine
  property p_release_owner;
    @(posedge clk) disable iff (!nrst)
    (state_reg == S_EXEC && opcode == OP_RELEASE && !other_owns) |=> !resv_reg;
  endproperty
  a_release_owner: assert property (p_release_owner) else $error("release kept"); // RULE1
  property p_release_other;
    @(posedge clk) disable iff (!nrst)
    (state_reg == S_EXEC && other_owns && !go)
      |=> (status_reg == ST_CONFLICT) && $stable(owner_reg);
  endproperty
  a_release_other: assert property (p_release_other) else $error("no conflict"); // RULE2
  property p_erase_once;
    @(posedge clk) disable iff (!nrst)
    (drive_req && drive_op == M_ERASE && drive_done) |=> (state_reg == S_FINISH);
  endproperty
  a_erase_once: assert property (p_erase_once) else $error("erase repeated"); // RULE3
  property p_erase_start;
    @(posedge clk) disable iff (!nrst)
    (state_reg == S_EXEC && !other_owns && opcode == OP_ERASE && !tape_start_marker)
      |=> (status_reg == ST_CHECK) && (sense_reg == SK_ILLEGAL) && state_reg == S_IDLE;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase off marker"); // RULE4
  property p_erase_bit;
    @(posedge clk) disable iff (!nrst)
    (state_reg == S_EXEC && !other_owns && opcode == OP_ERASE && !byte1[0])
      |=> sense_reg == SK_ILLEGAL;
  endproperty
  a_erase_bit: assert property (p_erase_bit) else $error("erase bit ignored"); // RULE5
  property p_disc_motion;
    @(posedge clk) disable iff (!nrst)
    (disc_reg && state_reg == S_FINISH) |=> (!disc_reg && recon_reg) ##1 !recon_reg;
  endproperty
  a_disc_motion: assert property (p_disc_motion) else $error("no reconnect"); // RULE6
  property p_sense_count;
    @(posedge clk) disable iff (!nrst)
    (state_reg == S_EXEC && !other_owns && opcode == OP_SENSE)
      |=> count_reg <= REC_LEN;
  endproperty
  a_sense_count: assert property (p_sense_count) else $error("count over record"); // RULE8
  property p_retension_flag_first;
    @(posedge clk) disable iff (!nrst)
    $rose(drive_req) && retension_flag_reg |-> drive_op == M_REWIND;
  endproperty
  a_retension_flag_first: assert property (p_retension_flag_first) else $error("retension order"); // RULE10
  property p_late_status;
    @(posedge clk) disable iff (!nrst)
    (state_reg == S_MOTION && !immed_reg && !go) |=> $stable(status_reg);
  endproperty
  a_late_status: assert property (p_late_status) else $error("early status"); // RULE14
  property p_busy_answer;
    @(posedge clk) disable iff (!nrst)
    (go && busy_reg) |=> (status_reg == ST_BUSYC) && done_reg;
  endproperty
  a_busy_answer: assert property (p_busy_answer) else $error("no busy"); // RULE16
endmodule // tape_unit_command_handler

/* File: rtl/tape_cmd_pkg.sv */
// constants, encodings and register map of the tape unit command handler
// assumes an apb master in front and a drive sequencer behind
package tape_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CDB_LO = 8'h00; // command bytes 0..3
  localparam logic [7:0] ADDR_CDB_HI = 8'h04; // bytes 4..5, host id, disconnect ok
  localparam logic [7:0] ADDR_CTRL = 8'h08; // go, bus clear, acknowledge
  localparam logic [7:0] ADDR_STATUS = 8'h0c; // ending status and state
  localparam logic [7:0] ADDR_MODE = 8'h10; // configuration record window
  localparam logic [7:0] ADDR_SETP = 8'h14; // set-parameters track count
  // control bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_BUS_CLEAR = 1;
  localparam int CTRL_ACK = 2;
  // command-high fields
  localparam int HI_ID_LSB = 16;
  localparam int HI_DISC = 20;
  localparam int MODE_WE = 16; // record write enable bit
  // status register field positions
  localparam int ST_SENSE_LSB = 8;
  localparam int ST_DONE = 12;
  localparam int ST_BUSY = 13;
  localparam int ST_DISC = 14;
  localparam int ST_RESV = 15;
  localparam int ST_OWNER_LSB = 16;
  localparam int ST_LUN_LSB = 20;
  localparam int ST_COUNT_LSB = 24;
  // opcodes
  localparam logic [7:0] OP_RESERVE = 8'h16;
  localparam logic [7:0] OP_RELEASE = 8'h17;
  localparam logic [7:0] OP_ERASE = 8'h19;
  localparam logic [7:0] OP_SENSE = 8'h1a;
  localparam logic [7:0] OP_LOADU = 8'h1b;
  // status bytes and sense keys
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_BUSYC = 8'h08;
  localparam logic [7:0] ST_CONFLICT = 8'h18;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  // configuration record
  localparam logic [4:0] REC_LEN = 5'h11;
  localparam logic [4:0] TRACKS_IDX = 5'h0d;
  // motion sequence steps
  localparam logic [2:0] STEP_FIRST = 3'h0;
  localparam logic [2:0] STEP_TO_END = 3'h1;
  localparam logic [2:0] RETENSION_FLAG_STEPS = 3'h3;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_EXEC = 2'b01, S_MOTION = 2'b11,
                            S_FINISH = 2'b10} state_t;
  typedef enum logic [2:0] {M_NONE = 3'h0, M_REWIND = 3'h1, M_TO_END = 3'h2,
                            M_ERASE = 3'h3, M_LOAD = 3'h4} motion_t;
endpackage

/* File: tb/drive_seq_model.sv */
// behavioural drive sequencer behind the tape command handler
// assumes drive_req stays high for the whole motion and drive_op is stable meanwhile
module drive_seq_model import tape_cmd_pkg::*; #(
  parameter int DELAY = 40 // cycles from request to completion
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // motion request from the handler
  input wire logic drive_req,
  input wire logic [2:0] drive_op,
  // completion and position back to the handler
  output logic drive_done,
  output logic tape_start_marker
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt; // 0 idle, else cycles spent on the motion

  // one motion at a time, one-cycle done pulse, position follows the motion
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 8'h00;
      drive_done <= 1'b0;
      tape_start_marker <= 1'b1;
    end else begin
      drive_done <= 1'b0;
      if (drive_done) begin
        // skip the cycle of the pulse, the next op is not yet presented
        cnt <= 8'h00;
      end else if (cnt == 8'h00) begin
        if (drive_req) begin
          cnt <= 8'h01;
        end
      end else if (cnt == 8'(DELAY)) begin
        drive_done <= 1'b1;
        cnt <= 8'h00;
        tape_start_marker <= (drive_op == M_REWIND) || (drive_op == M_LOAD);
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule // drive_seq_model

/* File: tb/tape_unit_command_handler_test.sv */
// self-checking bench for the tape unit command handler
// assumes zero-wait apb and the drive sequencer model on the drive side
module tape_unit_command_handler_test import tape_cmd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st, rd;
  logic drive_req, drive_done, tape_start_marker, disconnected, reconnect;
  logic [2:0] drive_op;
  logic [31:0] ops; // completed motions, one nibble each
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_recon = 0;
  bit saw_disc = 0;

  // design under test
  tape_unit_command_handler dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_req(drive_req), .drive_op(drive_op), .drive_done(drive_done),
    .tape_start_marker(tape_start_marker), .disconnected(disconnected),
    .reconnect(reconnect));
  // drive side
  drive_seq_model #(.DELAY(40)) drv (.clk(clk), .nrst(nrst), .drive_req(drive_req),
    .drive_op(drive_op), .drive_done(drive_done), .tape_start_marker(tape_start_marker));

  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // motion log, link watch and hang limit
  always @(posedge clk) begin
    cyc++;
    if (drive_done === 1'b1) ops = {ops[27:0], 1'b0, drive_op};
    if (reconnect === 1'b1) n_recon++;
    if (disconnected === 1'b1) saw_disc = 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, read data and error taken at the completing edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // command bytes 4, 5, host id and disconnect permission
  function automatic logic [20:0] hi(input logic d, input logic [2:0] id,
                                     input logic [7:0] b5, input logic [7:0] b4);
    return {d, 1'b0, id, b5, b4};
  endfunction

  // load command, go, poll for done, acknowledge
  task cmd(input logic [15:0] lo, input logic [20:0] h);
    ops = 32'h0;
    n_recon = 0;
    saw_disc = 0;
    apb(1'b1, ADDR_CDB_LO, {16'h0, lo});
    apb(1'b1, ADDR_CDB_HI, {11'h0, h});
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_GO);
    rd = 32'h0;
    for (int i = 0; i < 300 && rd[ST_DONE] !== 1'b1; i++) apb(1'b0, ADDR_STATUS, 32'h0);
    if (rd[ST_DONE] !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH at %0t: command never done", $time);
    end
    st = rd;
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_ACK);
  endtask

  // verdict
  task end_sim();
    $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // reset values and unmapped place
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({drive_req, disconnected, reconnect}, 3'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[7:0]}, 9'h100);
    $display("test reset done");
    // reservation by host 1, foreign release and access
    cmd({8'h00, OP_RESERVE}, hi(1'b0, 3'h1, 8'h00, 8'h00));
    cmd({8'h00, OP_RELEASE}, hi(1'b0, 3'h2, 8'h00, 8'h00));
    chk(st[7:0], ST_CONFLICT);
    chk(st[18:15], 4'h3);
    cmd({8'h00, OP_SENSE}, hi(1'b0, 3'h2, 8'h00, 8'h03));
    chk(st[7:0], ST_CONFLICT);
    cmd({8'h00, OP_RELEASE}, hi(1'b0, 3'h1, 8'h00, 8'h00));
    chk({st[ST_RESV], st[7:0]}, {1'b0, ST_GOOD});
    cmd({8'h00, OP_RESERVE}, hi(1'b0, 3'h3, 8'h00, 8'h00));
    chk(st[ST_RESV], 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_BUS_CLEAR);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_RESV], 1'b0);
    $display("test reservation done");
    // set-parameters value in the record, then sense counts and lun
    apb(1'b1, ADDR_MODE, {27'h0, TRACKS_IDX});
    apb(1'b1, ADDR_SETP, 32'h07);
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rd[15:0], {8'h07, 3'h0, TRACKS_IDX});
    cmd({8'ha0, OP_SENSE}, hi(1'b0, 3'h1, 8'h00, 8'h30));
    chk(st[ST_LUN_LSB+:3], 3'h5);
    chk(st[ST_COUNT_LSB+:5], REC_LEN);
    cmd({8'h00, OP_SENSE}, hi(1'b0, 3'h1, 8'h00, 8'h03));
    chk(st[ST_COUNT_LSB+:5], 5'h03);
    $display("test mode sense done");
    cmd({8'h00, OP_LOADU}, hi(1'b1, 3'h1, 8'h00, 8'h03));
    chk(ops, 32'h1214);
    chk({saw_disc, disconnected, st[7:0]}, {2'b10, ST_GOOD});
    chk(n_recon, 1);
    // unload to end marker, no disconnect: status after motion
    cmd({8'h00, OP_LOADU}, hi(1'b0, 3'h1, 8'h80, 8'h00));
    chk(ops, 32'h2);
    chk({saw_disc, st[7:0]}, {1'b0, ST_GOOD});
    // erase away from start marker
    cmd({8'h01, OP_ERASE}, hi(1'b1, 3'h1, 8'h00, 8'h00));
    chk({ops[3:0], st[11:0]}, {4'h0, SK_ILLEGAL, ST_CHECK});
    cmd({8'h00, OP_LOADU}, hi(1'b0, 3'h1, 8'h00, 8'h00));
    chk(ops, 32'h1);
    // erase with byte 1 bit 0 clear
    cmd({8'h00, OP_ERASE}, hi(1'b1, 3'h1, 8'h00, 8'h00));
    chk({ops[3:0], st[11:0]}, {4'h0, SK_ILLEGAL, ST_CHECK});
    // proper erase with disconnect
    cmd({8'h01, OP_ERASE}, hi(1'b1, 3'h1, 8'h00, 8'h00));
    chk({ops[7:0], st[7:0]}, {8'h03, ST_GOOD});
    chk({saw_disc, disconnected}, 2'b10);
    chk(n_recon, 1);
    $display("test motion done");
    // immediate load, then a command during motion
    cmd({8'h01, OP_LOADU}, hi(1'b0, 3'h1, 8'h00, 8'h01));
    chk({ops[3:0], st[ST_BUSY], st[7:0]}, {4'h0, 1'b1, ST_GOOD});
    cmd({8'h00, OP_RELEASE}, hi(1'b0, 3'h1, 8'h00, 8'h00));
    chk(st[7:0], ST_BUSYC);
    rd = 32'hffffffff;
    for (int i = 0; i < 100 && rd[ST_BUSY] !== 1'b0; i++) apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_BUSY], 1'b0);
    chk(ops, 32'h4);
    $display("test immediate done");
    end_sim();
  end
endmodule // tape_unit_command_handler_test
